// file: logic/boot_image_pkg.sv
package boot_image_pkg;

	// image layout
	localparam logic [23:0] HDR_ADDR = 24'h000000;
	localparam logic [3:0] HDR_BYTES = 4'hf;
	localparam logic [3:0] BLK_HDR_BYTES = 4'h7;
	localparam logic [3:0] FOOT_BYTES = 4'h7;
	localparam logic [7:0] SENTINEL = 8'haa;
	localparam logic [23:0] FIRST_BLOCK_DEFAULT = 24'h000010;
	localparam logic [3:0] CMD_BYTES = 4'h3;

	// header byte positions
	localparam logic [3:0] HB_SENT = 4'h0;
	localparam logic [3:0] HB_PTR_LO = 4'h3;
	localparam logic [3:0] HB_IN_DIV = 4'h5;
	localparam logic [3:0] HB_FB_DIV = 4'h7;
	localparam logic [3:0] HB_PLL_CK = 4'h9;
	localparam logic [3:0] HB_MCLK = 4'hb;
	localparam logic [3:0] HB_SPEED0 = 4'hc;

	// block header byte positions
	localparam logic [3:0] BB_FLAGS = 4'h0;
	localparam logic [3:0] BB_MEM = 4'h1;
	localparam logic [3:0] BB_BASE_LO = 4'h3;
	localparam logic [3:0] BB_LEN_HI = 4'h4;
	localparam logic [3:0] BB_LEN_LO = 4'h5;
	localparam logic [3:0] BB_JUMP_HI = 4'h6;
	localparam int LAST_FLAG_BIT = 7;

	// memory select codes
	localparam logic [1:0] MEM_DATA0 = 2'h0;
	localparam logic [1:0] MEM_DATA1 = 2'h1;
	localparam logic [1:0] MEM_PROG = 2'h2;
	localparam logic [1:0] MEM_BAD = 2'h3;

	// serial read command
	localparam logic [7:0] CMD_SEQ_READ = 8'h03;

	// retries
	localparam logic [1:0] LAST_ATTEMPT = 2'h2;

	// failure codes
	localparam logic [2:0] FAIL_NONE = 3'h0;
	localparam logic [2:0] FAIL_SENTINEL = 3'h1;
	localparam logic [2:0] FAIL_PLL = 3'h2;
	localparam logic [2:0] FAIL_MEMSEL = 3'h3;
	localparam logic [2:0] FAIL_CHECKSUM = 3'h4;

	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SCK_MIN_PERIOD_NS = 1000;
	localparam int SS_GAP_MIN_NS = 100;
	localparam int SCK_HALF_CYC =
		(SCK_MIN_PERIOD_NS * 1000 + 2 * CLK_PERIOD_PS - 1) /
		(2 * CLK_PERIOD_PS);
	localparam int SS_GAP_CYC =
		(SS_GAP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SEL = 4'h1,
		ST_CMD = 4'h3,
		ST_HDR = 4'h2,
		ST_BLKH = 4'h6,
		ST_DATA = 4'h7,
		ST_FOOT = 4'h5,
		ST_CHECK = 4'h4,
		ST_DONE = 4'hc,
		ST_FAIL = 4'hd,
		ST_SLEEP = 4'hf
	} boot_state_t;

	typedef struct packed {
		logic [1:0] sel;
		logic [15:0] addr;
		logic [31:0] data;
	} mem_wr_t;

	typedef struct packed {
		logic [7:0] in_div;
		logic [7:0] pll_feedback_divider;
		logic [7:0] pll_cksum;
		logic [7:0] mclk_out;
		logic [31:0] speed;
	} pll_cfg_t;

endpackage

// file: logic/eeprom_spi_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_spi_shifter
	import boot_image_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYC
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// byte request
	input wire logic go_in,
	input wire logic [7:0] tx_in,
	output var logic busy_out,
	output var logic done_out,
	output var logic [7:0] rx_out,
	// serial pins
	input wire logic miso_in,
	output var logic sclk_out,
	output var logic mosi_out
);
	logic [15:0] div_r;
	logic [3:0] bits_r;
	logic [7:0] sh_r;
	logic tick;

	assign tick = (div_r == 16'(HALF - 1));

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			div_r <= 16'h0000;
		else if (!busy_out || tick)
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
	end

	// R20 msb first
	// R22 mode 3 shifting: idle high, launch on fall, sample on rise
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			rx_out <= 8'h00;
			sclk_out <= 1'b1;
			mosi_out <= 1'b1;
			sh_r <= 8'h00;
			bits_r <= 4'h0;
		end
		else
		begin
			done_out <= 1'b0;
			if (go_in && !busy_out)
			begin
				busy_out <= 1'b1;
				sh_r <= tx_in;
				bits_r <= 4'h0;
			end
			else if (busy_out && tick)
			begin
				if (sclk_out)
				begin
					sclk_out <= 1'b0;
					mosi_out <= sh_r[7];
				end
				else
				begin
					sclk_out <= 1'b1;
					sh_r <= {sh_r[6:0], miso_in};
					bits_r <= bits_r + 4'h1;
					if (bits_r == 4'h7)
					begin
						busy_out <= 1'b0;
						done_out <= 1'b1;
						rx_out <= {sh_r[6:0], miso_in};
					end
				end
			end
		end
	end

	sclk_idle_a: assert property ( // R22
		@(posedge clk_in) disable iff (rst_in)
		!busy_out |-> sclk_out)
		else $error("serial clock not high while idle");

endmodule
`default_nettype wire

// file: logic/boot_image_loader.sv
// Functional notes
// R1 - image header is 16 bytes at eeprom address zero, read first
// R2 - first header byte must be sentinel 0xaa or the attempt fails
// R3 - header bytes 1..3 point to first block; default 0x000010
// R4 - pll checksum byte equals input div plus feedback div plus mclk
// R5 - header bytes 4,6,8,10 zero; 5,7,9,11 pll fields; 12..15 speed
// R6 - each block starts with eight header bytes then 4-byte packets
// R7 - last block flag set means footer follows, clear means more blocks
// R8 - producer writes the 13 reserved block header bits as zero
// R9 - memory select 0 data0, 1 data1, 2 program memory
// R10 - block data written starting at the 16-bit base address
// R11 - length field counts 32-bit words; consume exactly that many
// R12 - jump address used only from the block with last flag set
// R13 - block header: flags, select, base, length, jump in that order
// R14 - footer holds 64-bit sum of header, block headers, data words
// R15 - footer first four bytes upper half, next four lower half
// R16 - checksum mismatch after load is a failure signalled as panic
// R17 - zero footer checksum disables checking
// R18 - boot only from the eeprom on the primary slave select
// R19 - split i2c eeprom part at other chip address never read
// R20 - data transferred most significant bit first
// R21 - three attempts; after third failure panic then sleep
// R22 - spi boot uses sequential read 0x03 in mode 3
`timescale 1ns/10ps
`default_nettype none
module boot_image_loader
	import boot_image_pkg::*;
#(
	parameter int SCK_HALF = SCK_HALF_CYC,
	parameter int SS_GAP = SS_GAP_CYC,
	parameter int SEC_SELECTS = 7
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// control
	input wire logic boot_start_in,
	// serial eeprom pins
	input wire logic miso_in,
	output var logic sclk_out,
	output var logic mosi_out,
	output var logic ss_n_out,
	output var logic [SEC_SELECTS-1:0] ss_sec_n_out,
	// memory write port
	output var logic mem_wr_valid_out,
	output var boot_image_pkg::mem_wr_t mem_wr_out,
	// results
	output var boot_image_pkg::pll_cfg_t pll_cfg_out,
	output var logic [15:0] jump_addr_out,
	output var logic boot_done_out,
	output var logic panic_out,
	output var logic [2:0] panic_code_out,
	output var logic sleep_out
);
	import boot_image_pkg::*;

	boot_state_t st_r;
	boot_state_t next_st_r;
	logic [23:0] rd_addr_r;
	logic [23:0] ptr_r;
	logic [3:0] cnt_r;
	logic [15:0] gap_r;
	logic [1:0] attempt_r;
	logic [23:0] word_r;
	logic [63:0] sum_r;
	logic [63:0] foot_r;
	logic last_r;
	logic [1:0] sel_r;
	logic [15:0] base_r;
	logic [15:0] len_r;
	logic [15:0] dcnt_r;
	logic [7:0] jump_hi_r;
	logic go_r;
	logic [7:0] tx_r;
	logic busy;
	logic done;
	logic [7:0] rx;
	logic [31:0] wd;
	logic word_end;
	logic reading;

	function automatic logic [7:0] pick_byte(input logic [23:0] a,
		input logic [3:0] i);
		case (i)
			4'h1: pick_byte = a[23:16];
			4'h2: pick_byte = a[15:8];
			4'h3: pick_byte = a[7:0];
			default: pick_byte = CMD_SEQ_READ;
		endcase
	endfunction

	assign wd = {word_r, rx};
	assign word_end = done && (cnt_r[1:0] == 2'h3);
	assign reading = (st_r == ST_CMD) || (st_r == ST_HDR) ||
		(st_r == ST_BLKH) || (st_r == ST_DATA) || (st_r == ST_FOOT);

	eeprom_spi_shifter #(.HALF(SCK_HALF)) shifter (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.go_in(go_r),
		.tx_in(tx_r),
		.busy_out(busy),
		.done_out(done),
		.rx_out(rx),
		.miso_in(miso_in),
		.sclk_out(sclk_out),
		.mosi_out(mosi_out)
	);

	// R22 command then address, zeros while reading
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			go_r <= 1'b0;
			tx_r <= 8'h00;
		end
		else
		begin
			go_r <= reading && !busy && !go_r && !done;
			tx_r <= (st_r == ST_CMD) ? pick_byte(rd_addr_r, cnt_r) : 8'h00;
		end
	end

	// R18 only the primary select is ever driven low
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ss_n_out <= 1'b1;
			ss_sec_n_out <= '1;
		end
		else
		begin
			ss_n_out <= !reading;
			ss_sec_n_out <= '1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			word_r <= 24'h000000;
		else if (done)
			word_r <= wd[23:0];
	end

	// R14 sum of all words before the footer
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			sum_r <= 64'h0;
		else if (st_r == ST_SEL && next_st_r == ST_HDR)
			sum_r <= 64'h0;
		else if (word_end && (st_r == ST_HDR || st_r == ST_BLKH ||
			st_r == ST_DATA))
			sum_r <= sum_r + {32'h0, wd};
	end

	// R9 routed writes, R10 from the base address
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			mem_wr_valid_out <= 1'b0;
			mem_wr_out <= '0;
		end
		else
		begin
			mem_wr_valid_out <= (st_r == ST_DATA) && word_end;
			if ((st_r == ST_DATA) && word_end)
				mem_wr_out <= '{sel: sel_r, addr: base_r + dcnt_r, data: wd};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			boot_done_out <= 1'b0;
			sleep_out <= 1'b0;
			panic_out <= 1'b0;
		end
		else
		begin
			boot_done_out <= (st_r == ST_DONE);
			sleep_out <= (st_r == ST_SLEEP);
			// R21 panic only once the last attempt has failed
			if (st_r == ST_FAIL && attempt_r == LAST_ATTEMPT)
				panic_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r <= ST_IDLE;
			next_st_r <= ST_HDR;
			rd_addr_r <= HDR_ADDR;
			ptr_r <= 24'h0;
			cnt_r <= 4'h0;
			gap_r <= 16'h0;
			attempt_r <= 2'h0;
			foot_r <= 64'h0;
			last_r <= 1'b0;
			sel_r <= MEM_DATA0;
			base_r <= 16'h0;
			len_r <= 16'h0;
			dcnt_r <= 16'h0;
			jump_hi_r <= 8'h0;
			jump_addr_out <= 16'h0;
			pll_cfg_out <= '0;
			panic_code_out <= FAIL_NONE;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
					// R1 header read first from address zero
					if (boot_start_in)
					begin
						rd_addr_r <= HDR_ADDR;
						next_st_r <= ST_HDR;
						attempt_r <= 2'h0;
						gap_r <= 16'h0;
						st_r <= ST_SEL;
					end
				ST_SEL:
					// keeps select high long enough between frames
					if (gap_r == 16'(SS_GAP - 1))
					begin
						cnt_r <= 4'h0;
						st_r <= ST_CMD;
					end
					else
						gap_r <= gap_r + 16'h1;
				ST_CMD:
					if (done)
					begin
						cnt_r <= (cnt_r == CMD_BYTES) ? 4'h0 : cnt_r + 4'h1;
						if (cnt_r == CMD_BYTES)
							st_r <= next_st_r;
					end
				ST_HDR:
					if (done)
					begin
						cnt_r <= cnt_r + 4'h1;
						// R5 header field positions
						case (cnt_r)
							HB_IN_DIV: pll_cfg_out.in_div <= rx;
							HB_FB_DIV: pll_cfg_out.pll_feedback_divider <= rx;
							HB_PLL_CK: pll_cfg_out.pll_cksum <= rx;
							HB_MCLK: pll_cfg_out.mclk_out <= rx;
							default: ;
						endcase
						if (cnt_r >= HB_SPEED0)
							pll_cfg_out.speed <= wd;
						if (cnt_r <= HB_PTR_LO)
							ptr_r <= wd[23:0];
						// R2 sentinel check
						if (cnt_r == HB_SENT && rx != SENTINEL)
						begin
							panic_code_out <= FAIL_SENTINEL;
							st_r <= ST_FAIL;
						end
						// R5 padding bytes must be zero
						else if (!cnt_r[0] && cnt_r >= 4'h4 &&
							cnt_r < HB_SPEED0 && rx != 8'h00)
						begin
							panic_code_out <= FAIL_PLL;
							st_r <= ST_FAIL;
						end
						else if (cnt_r == HB_SPEED0 &&
							pll_cfg_out.pll_cksum != pll_cfg_out.in_div +
							pll_cfg_out.pll_feedback_divider +
							pll_cfg_out.mclk_out)
						begin
							// R4 pll checksum
							panic_code_out <= FAIL_PLL;
							st_r <= ST_FAIL;
						end
						else if (cnt_r == HDR_BYTES)
						begin
							cnt_r <= 4'h0;
							// R3 jump to the first block when not adjacent
							if (ptr_r == FIRST_BLOCK_DEFAULT)
								st_r <= ST_BLKH;
							else
							begin
								rd_addr_r <= ptr_r;
								next_st_r <= ST_BLKH;
								gap_r <= 16'h0;
								st_r <= ST_SEL;
							end
						end
					end
				ST_BLKH:
					if (done)
					begin
						cnt_r <= cnt_r + 4'h1;
						// R13 block header byte order, R6 eight bytes
						case (cnt_r)
							BB_FLAGS: last_r <= rx[LAST_FLAG_BIT];
							BB_MEM: sel_r <= rx[1:0];
							BB_BASE_LO: base_r <= wd[15:0];
							BB_LEN_HI: len_r[15:8] <= rx;
							BB_LEN_LO: len_r[7:0] <= rx;
							BB_JUMP_HI: jump_hi_r <= rx;
							default: ;
						endcase
						// R9 only three targets exist
						if (cnt_r == BB_BASE_LO && sel_r == MEM_BAD)
						begin
							panic_code_out <= FAIL_MEMSEL;
							st_r <= ST_FAIL;
						end
						else if (cnt_r == BLK_HDR_BYTES)
						begin
							cnt_r <= 4'h0;
							dcnt_r <= 16'h0;
							// R12 jump taken only from the last block
							if (last_r)
								jump_addr_out <= {jump_hi_r, rx};
							// R7 footer follows the last block
							if (len_r != 16'h0)
								st_r <= ST_DATA;
							else if (last_r)
								st_r <= ST_FOOT;
						end
					end
				ST_DATA:
					if (done)
					begin
						cnt_r <= cnt_r + 4'h1;
						// R11 exactly len words
						if (word_end)
						begin
							dcnt_r <= dcnt_r + 16'h1;
							if (dcnt_r + 16'h1 == len_r)
							begin
								cnt_r <= 4'h0;
								st_r <= last_r ? ST_FOOT : ST_BLKH;
							end
						end
					end
				ST_FOOT:
					if (done)
					begin
						// R15 upper half arrives first
						foot_r <= {foot_r[55:0], rx};
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == FOOT_BYTES)
							st_r <= ST_CHECK;
					end
				ST_CHECK:
					// R17 zero disables, R16 mismatch fails
					if (foot_r == 64'h0 || foot_r == sum_r)
						st_r <= ST_DONE;
					else
					begin
						panic_code_out <= FAIL_CHECKSUM;
						st_r <= ST_FAIL;
					end
				ST_DONE: ;
				ST_FAIL:
					// R21 retry from the header
					if (attempt_r == LAST_ATTEMPT)
						st_r <= ST_SLEEP;
					else
					begin
						attempt_r <= attempt_r + 2'h1;
						rd_addr_r <= HDR_ADDR;
						next_st_r <= ST_HDR;
						gap_r <= 16'h0;
						st_r <= ST_SEL;
					end
				ST_SLEEP: ;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	start_addr_a: assert property ( // R1
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_IDLE && boot_start_in) |=>
			(rd_addr_r == HDR_ADDR && next_st_r == ST_HDR))
		else $error("boot did not start at header address");

	sentinel_fail_a: assert property ( // R2
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_HDR && done && cnt_r == 4'h0 && rx != 8'haa) |=>
			(st_r == ST_FAIL && panic_code_out == FAIL_SENTINEL))
		else $error("bad sentinel accepted");

	mem_route_a: assert property ( // R9
		@(posedge clk_in) disable iff (rst_in)
		mem_wr_valid_out |-> (mem_wr_out.sel != 2'h3))
		else $error("write to undefined memory");

	base_addr_a: assert property ( // R10
		@(posedge clk_in) disable iff (rst_in)
		(mem_wr_valid_out && dcnt_r == 16'h1) |->
			(mem_wr_out.addr == base_r))
		else $error("first word not at base address");

	word_count_a: assert property ( // R11
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_DATA ##1 st_r != ST_DATA) |-> (dcnt_r == len_r))
		else $error("block word count wrong");

	jump_last_a: assert property ( // R12
		@(posedge clk_in) disable iff (rst_in)
		$changed(jump_addr_out) |-> $past(last_r))
		else $error("jump taken from non-last block");

	check_skip_a: assert property ( // R17
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_CHECK && foot_r == 64'h0) |=> (st_r == ST_DONE))
		else $error("zero checksum not skipped");

	final_panic_a: assert property ( // R21
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_FAIL && attempt_r == 2'h2) |=>
			(panic_out && st_r == ST_SLEEP) ##1 sleep_out)
		else $error("third failure did not panic and sleep");

	sec_select_a: assert property ( // R18
		@(posedge clk_in) disable iff (rst_in)
		ss_sec_n_out == '1)
		else $error("secondary select asserted");

	read_cmd_a: assert property ( // R22
		@(posedge clk_in) disable iff (rst_in)
		(st_r == ST_CMD && go_r && cnt_r == 4'h0) |-> (tx_r == 8'h03))
		else $error("wrong read command");

endmodule
`default_nettype wire

// file: tb/spi_eeprom_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_model
(
	// serial pins
	input wire logic ss_n_in,
	input wire logic sclk_in,
	input wire logic mosi_in,
	output var logic miso_out,
	// observation
	output var logic cmd_bad_out,
	output var logic [23:0] addr_out,
	output var logic [7:0] frames_out
);
	// only the boot device's own space
	logic [7:0] mem [0:255];
	logic [31:0] sh;
	logic [7:0] dbyte;
	logic [7:0] rd_ptr;
	int cnt;
	int bitn;
	initial
	begin
		miso_out = 1'b0;
		cmd_bad_out = 1'b0;
		addr_out = 24'h000000;
		frames_out = 8'h00;
		cnt = 0;
		bitn = 8;
	end
	always @(negedge ss_n_in)
	begin
		cnt = 0;
		frames_out = frames_out + 8'h01;
	end
	// a released line must not keep showing the last bit
	always @(posedge ss_n_in)
		miso_out = ~miso_out;
	always @(posedge sclk_in)
		if (!ss_n_in && cnt < 32)
		begin
			sh = {sh[30:0], mosi_in};
			cnt = cnt + 1;
			if (cnt == 32)
			begin
				if (sh[31:24] != 8'h03)
					cmd_bad_out = 1'b1;
				addr_out = sh[23:0];
				rd_ptr = sh[7:0];
				bitn = 8;
			end
		end
	always @(negedge sclk_in)
		if (!ss_n_in && cnt == 32)
		begin
			if (bitn == 8)
			begin
				dbyte = mem[rd_ptr];
				rd_ptr = rd_ptr + 8'h01;
				bitn = 0;
			end
			miso_out = dbyte[7];
			dbyte = {dbyte[6:0], 1'b0};
			bitn = bitn + 1;
		end
endmodule
`default_nettype wire

// file: tb/eeprom_self_boot_image_loader_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_self_boot_image_loader_bench;
	import boot_image_pkg::*;
	typedef struct packed {
		logic last;
		logic [1:0] sel;
		logic [15:0] base;
		logic [15:0] len;
		logic [15:0] jump;
	} blk_row_t;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] v;
		logic [2:0] code;
	} bad_row_t;
	localparam int NB = 3;
	localparam blk_row_t ROWS [NB] = '{
		'{1'b0, MEM_PROG, 16'h0100, 16'h0002, 16'hdead},
		'{1'b0, MEM_DATA0, 16'h0040, 16'h0000, 16'hbeef},
		'{1'b1, MEM_DATA1, 16'h7ffe, 16'h0003, 16'h1234}};
	// the select fault sits in the third block, after two non-last
	// blocks whose jump fields must not reach the jump output
	localparam bad_row_t BADS [4] = '{
		'{8'h00, 8'h55, FAIL_SENTINEL},
		'{8'h09, 8'h0b, FAIL_PLL},
		'{8'h06, 8'h01, FAIL_PLL},
		'{8'h29, 8'h03, FAIL_MEMSEL}};
	logic clk_in;
	logic rst_in;
	logic boot_start;
	logic miso;
	logic sclk;
	logic mosi;
	logic ss_n;
	logic [6:0] ss_sec_n;
	logic mem_wr_valid;
	mem_wr_t mem_wr;
	pll_cfg_t pll_cfg;
	logic [15:0] jump;
	logic done;
	logic panic;
	logic [2:0] code;
	logic sleep;
	logic cmd_bad;
	logic [23:0] rom_addr;
	logic [7:0] frames;
	logic sec_bad;
	logic idle_bad;
	logic [63:0] sum;
	mem_wr_t exp_q [$];
	mem_wr_t got_q [$];
	int err_count;
	int checked;
	int cycles;
	int k;

	boot_image_loader #(.SCK_HALF(2), .SS_GAP(2)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .boot_start_in(boot_start),
		.miso_in(miso), .sclk_out(sclk), .mosi_out(mosi), .ss_n_out(ss_n),
		.ss_sec_n_out(ss_sec_n), .mem_wr_valid_out(mem_wr_valid),
		.mem_wr_out(mem_wr), .pll_cfg_out(pll_cfg), .jump_addr_out(jump),
		.boot_done_out(done), .panic_out(panic), .panic_code_out(code),
		.sleep_out(sleep));
	spi_eeprom_model u_rom (
		.ss_n_in(ss_n), .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso),
		.cmd_bad_out(cmd_bad), .addr_out(rom_addr), .frames_out(frames));

	initial
	begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		boot_start = 1'b0;
		err_count = 0;
		checked = 0;
		cycles = 0;
		sec_bad = 1'b0;
		idle_bad = 1'b0;
	end
	always #2 clk_in = ~clk_in;

	task automatic test_done();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_in)
	begin
		cycles = cycles + 1;
		if (cycles == 60000)
		begin
			err_count = err_count + 1;
			$display("unexpected at %0t: run did not finish", $time);
			test_done();
		end
	end

	always @(negedge clk_in)
	begin
		if (mem_wr_valid === 1'b1)
			got_q.push_back(mem_wr);
		if (ss_sec_n !== 7'h7f)
			sec_bad = 1'b1;
		if (ss_n === 1'b1 && rst_in === 1'b0 && sclk !== 1'b1)
			idle_bad = 1'b1;
	end

	task automatic chk1(input logic got, input logic exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("unexpected at %0t: flag %b want %b", $time, got, exp);
		end
	endtask

	task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
		checked = checked + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("unexpected at %0t: value %h want %h", $time, got, exp);
		end
	endtask

	task automatic put_word(input logic [7:0] a, input logic [31:0] w,
		input logic add);
		u_rom.mem[a] = w[31:24];
		u_rom.mem[a + 8'h01] = w[23:16];
		u_rom.mem[a + 8'h02] = w[15:8];
		u_rom.mem[a + 8'h03] = w[7:0];
		if (add)
			sum = sum + {32'h0, w};
	endtask

	// foot: 0 right sum, 1 sum off by one, 2 zero
	task automatic build(input logic [7:0] ptr, input logic [1:0] foot);
		logic [7:0] a;
		logic [31:0] w;
		logic [63:0] fsum;
		sum = 64'h0;
		exp_q.delete();
		for (int i = 0; i < 256; i++)
			u_rom.mem[i] = 8'h5a;
		put_word(8'h00, {SENTINEL, 16'h0000, ptr}, 1'b1);
		put_word(8'h04, 32'h0002_0003, 1'b1);
		put_word(8'h08, 32'h000a_0005, 1'b1);
		put_word(8'h0c, 32'h0012_3456, 1'b1);
		a = ptr;
		for (int i = 0; i < NB; i++)
		begin
			put_word(a, {ROWS[i].last, 13'h0, ROWS[i].sel, ROWS[i].base}, 1'b1);
			put_word(a + 8'h04, {ROWS[i].len, ROWS[i].jump}, 1'b1);
			a = a + 8'h08;
			for (int j = 0; j < ROWS[i].len; j++)
			begin
				w = 32'hf1e2_d3c4 + {ROWS[i].base, 16'(j)};
				put_word(a, w, 1'b1);
				exp_q.push_back({ROWS[i].sel, ROWS[i].base + 16'(j), w});
				a = a + 8'h04;
			end
		end
		fsum = (foot == 2'h1) ? sum + 64'h1 : (foot == 2'h2) ? 64'h0 : sum;
		put_word(a, fsum[63:32], 1'b0);
		put_word(a + 8'h04, fsum[31:0], 1'b0);
	endtask

	task automatic boot();
		int n;
		// reset is raised on an edge like every other input
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		u_rom.frames_out = 8'h00;
		got_q.delete();
		@(posedge clk_in);
		boot_start <= 1'b1;
		@(posedge clk_in);
		boot_start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && sleep !== 1'b1 && n < 20000)
		begin
			@(posedge clk_in);
			n = n + 1;
		end
		repeat (4) @(posedge clk_in);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_in);
		#1;
		chkv({ss_n, sclk, mosi, done, panic, sleep}, 64'h38);
		// broken images: each must fail all three attempts
		for (k = 0; k < 4; k++)
		begin
			build(8'h10, 2'h0);
			u_rom.mem[BADS[k].a] = BADS[k].v;
			boot();
			chk1(panic, 1'b1);
			chk1(sleep, 1'b1);
			chkv(code, BADS[k].code);
			chkv(frames, 64'h3);
			chkv(jump, 64'h0);
		end
		// pointer past padding, three blocks with every memory select
		build(8'h20, 2'h0);
		boot();
		chk1(done, 1'b1);
		chk1(panic, 1'b0);
		chkv(jump, 64'h1234);
		chkv(pll_cfg, {8'h02, 8'h03, 8'h0a, 8'h05, 32'h0012_3456});
		chkv(frames, 64'h2);
		chkv(rom_addr, 64'h20);
		chkv(got_q.size(), exp_q.size());
		for (k = 0; k < exp_q.size(); k++)
			chkv(got_q[k], exp_q[k]);
		// footer sum off by one in the low half: three attempts then panic
		build(8'h10, 2'h1);
		boot();
		chk1(done, 1'b0);
		chk1(panic, 1'b1);
		chk1(sleep, 1'b1);
		chkv(code, FAIL_CHECKSUM);
		chkv(frames, 64'h3);
		chkv(rom_addr, 64'h0);
		// zero footer skips the check
		build(8'h10, 2'h2);
		boot();
		chk1(done, 1'b1);
		chk1(panic, 1'b0);
		chkv(frames, 64'h1);
		chk1(cmd_bad, 1'b0);
		chk1(sec_bad, 1'b0);
		chk1(idle_bad, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
